/* File: src/cdr_repeater.sv */
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module cdr_repeater (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // from activation sequencer
  input wire logic RX_ENABLE_IN,
  // line levels: bit0 data, bit1 aux one, bit2 aux two
  input wire cdr_pkg::cdr_lines_t HOST_LINE_IN,
  input wire cdr_pkg::cdr_lines_t CARD_LINE_IN,
  // line drivers, open drain: pin drives low while enabled
  output cdr_pkg::cdr_lines_t HOST_LINE_OUT,
  output cdr_pkg::cdr_lines_t HOST_LINE_OE_OUT,
  output cdr_pkg::cdr_lines_t CARD_LINE_OUT,
  output cdr_pkg::cdr_lines_t CARD_LINE_OE_OUT,
  // card side held low (outside reception)
  output logic CARD_HELD_LOW_OUT
);

  typedef struct packed {
    logic rx_on;
  } cdr_top_st_t;

  cdr_top_st_t st;
  cdr_top_st_t next_st;
  logic [cdr_pkg::CDR_PAIRS-1:0] host_low;
  logic [cdr_pkg::CDR_PAIRS-1:0] card_low;
  cdr_pkg::cdr_dir_t dirs [cdr_pkg::CDR_PAIRS];

  // ---------------------------------------------------------------
  // reception state
  // ---------------------------------------------------------------
  // sequencer enable follows
  always_comb begin
    next_st = st;
    next_st.rx_on = RX_ENABLE_IN;
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st.rx_on <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // one repeater per pair
  // ---------------------------------------------------------------
  for (genvar i = 0; i < cdr_pkg::CDR_PAIRS; i++) begin : g_pair
    cdr_pair u_pair (
      .clk(REF_CLK_IN),
      .rst(RST_IN),
      .rx_en(st.rx_on),
      .host_in(HOST_LINE_IN.lvl[i]),
      .card_in(CARD_LINE_IN.lvl[i]),
      .host_drive_low(host_low[i]),
      .card_drive_low(card_low[i]),
      .dir(dirs[i])
    );
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // open drain: only low is ever driven, pull-ups give high
  assign HOST_LINE_OUT.lvl = {cdr_pkg::CDR_PAIRS{1'b0}};
  assign CARD_LINE_OUT.lvl = {cdr_pkg::CDR_PAIRS{cdr_pkg::CDR_CARD_RST_LVL}};
  assign HOST_LINE_OE_OUT.lvl = st.rx_on ? host_low : {cdr_pkg::CDR_PAIRS{~cdr_pkg::CDR_HOST_RST_LVL}};
  assign CARD_LINE_OE_OUT.lvl = st.rx_on ? card_low : {cdr_pkg::CDR_PAIRS{1'b1}};
  assign CARD_HELD_LOW_OUT = ~st.rx_on;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_card_clamp;
    @(posedge REF_CLK_IN) disable iff (RST_IN)
      !st.rx_on |-> (CARD_LINE_OE_OUT.lvl == {cdr_pkg::CDR_PAIRS{1'b1}});
  endproperty
  a_card_clamp: assert property (p_card_clamp) else $error("card not clamped low");

  property p_rx_release;
    @(posedge REF_CLK_IN) disable iff (RST_IN)
      (RX_ENABLE_IN && !st.rx_on) |=> (CARD_LINE_OE_OUT.lvl == {cdr_pkg::CDR_PAIRS{1'b0}});
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("card not released");

  property p_host_idle;
    @(posedge REF_CLK_IN) disable iff (RST_IN)
      !st.rx_on |-> (HOST_LINE_OE_OUT.lvl == {cdr_pkg::CDR_PAIRS{1'b0}});
  endproperty
  a_host_idle: assert property (p_host_idle) else $error("host driven off session");

  property p_deact;
    @(posedge REF_CLK_IN) disable iff (RST_IN)
      (st.rx_on && !RX_ENABLE_IN) |=> (CARD_LINE_OE_OUT.lvl[0] && CARD_HELD_LOW_OUT);
  endproperty
  a_deact: assert property (p_deact) else $error("deactivate not clamping data");

  // ---------------------------------------------------------------
  // per-pair checks at the pins
  // ---------------------------------------------------------------
  // watched at the pins rather than inside the pair, so a slip in the
  // session mux or a crossed bit index shows up as well
  for (genvar j = 0; j < cdr_pkg::CDR_PAIRS; j++) begin : g_chk
    // pair idle in session, host line still high
    sequence s_host_idle;
      st.rx_on && dirs[j] == cdr_pkg::CDR_NEUTRAL && HOST_LINE_IN.lvl[j];
    endsequence

    // host line seen low while the pair is still idle
    sequence s_host_drop;
      st.rx_on && dirs[j] == cdr_pkg::CDR_NEUTRAL && !HOST_LINE_IN.lvl[j];
    endsequence

    // pair idle in session, card line still high
    sequence s_card_idle;
      st.rx_on && dirs[j] == cdr_pkg::CDR_NEUTRAL && CARD_LINE_IN.lvl[j];
    endsequence

    // card line seen low alone, host quiet
    sequence s_card_drop;
      st.rx_on && dirs[j] == cdr_pkg::CDR_NEUTRAL && !CARD_LINE_IN.lvl[j]
        && HOST_LINE_IN.lvl[j];
    endsequence

    // host side holds the pair as input, still low
    sequence s_host_held;
      st.rx_on && dirs[j] == cdr_pkg::CDR_HOST_IN && !HOST_LINE_IN.lvl[j];
    endsequence

    // host side seen high again, direction still set
    sequence s_host_back;
      dirs[j] == cdr_pkg::CDR_HOST_IN && HOST_LINE_IN.lvl[j];
    endsequence

    // card side holds the pair as input, still low
    sequence s_card_held;
      st.rx_on && dirs[j] == cdr_pkg::CDR_CARD_IN && !CARD_LINE_IN.lvl[j];
    endsequence

    // card side seen high again, direction still set
    sequence s_card_back;
      dirs[j] == cdr_pkg::CDR_CARD_IN && CARD_LINE_IN.lvl[j];
    endsequence

    // a fall seen at the pin picks its own side one edge later
    property p_host_pick;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        s_host_idle ##1 s_host_drop |=> (dirs[j] == cdr_pkg::CDR_HOST_IN);
    endproperty
    a_host_pick: assert property (p_host_pick) else $error("host fall not taken");

    property p_card_pick;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        s_card_idle ##1 s_card_drop |=> (dirs[j] == cdr_pkg::CDR_CARD_IN);
    endproperty
    a_card_pick: assert property (p_card_pick) else $error("card fall not taken");

    // both sides sunk at once would latch the pair low for good
    property p_one_side;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        st.rx_on |-> !(HOST_LINE_OE_OUT.lvl[j] && CARD_LINE_OE_OUT.lvl[j]);
    endproperty
    a_one_side: assert property (p_one_side) else $error("both sides of a pair sunk");

    property p_host_follow;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        (st.rx_on && dirs[j] == cdr_pkg::CDR_HOST_IN)
          |-> (CARD_LINE_OE_OUT.lvl[j] == !HOST_LINE_IN.lvl[j]);
    endproperty
    a_host_follow: assert property (p_host_follow) else $error("card pin not following");

    property p_card_follow;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        (st.rx_on && dirs[j] == cdr_pkg::CDR_CARD_IN)
          |-> (HOST_LINE_OE_OUT.lvl[j] == !CARD_LINE_IN.lvl[j]);
    endproperty
    a_card_follow: assert property (p_card_follow) else $error("host pin not following");

    // release takes one edge after the rise is sampled
    property p_host_release;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        s_host_held ##1 s_host_back |=> (dirs[j] == cdr_pkg::CDR_NEUTRAL);
    endproperty
    a_host_release: assert property (p_host_release) else $error("host rise kept pair");

    property p_card_release;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        s_card_held ##1 s_card_back |=> (dirs[j] == cdr_pkg::CDR_NEUTRAL);
    endproperty
    a_card_release: assert property (p_card_release) else $error("card rise kept pair");

    // neutral pair leaves both pins to their pull-ups
    property p_neutral_pins;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        (st.rx_on && dirs[j] == cdr_pkg::CDR_NEUTRAL)
          |-> !(HOST_LINE_OE_OUT.lvl[j] || CARD_LINE_OE_OUT.lvl[j]);
    endproperty
    a_neutral_pins: assert property (p_neutral_pins) else $error("neutral pair sinks a pin");

    // out of reception no direction survives the next edge
    property p_off_neutral;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
        !st.rx_on |=> (dirs[j] == cdr_pkg::CDR_NEUTRAL);
    endproperty
    a_off_neutral: assert property (p_off_neutral) else $error("direction kept off session");
  end

endmodule : cdr_repeater

/* File: src/cdr_pkg.sv */
package cdr_pkg;

  // ---------------------------------------------------------------
  // line pair direction
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CDR_NEUTRAL,
    CDR_HOST_IN,
    CDR_CARD_IN
  } cdr_dir_t;

  // ---------------------------------------------------------------
  // pin groups and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CDR_PAIRS = 3;

  // one bit per line pair: bit0 data, bit1 aux one, bit2 aux two
  typedef struct packed {
    logic [CDR_PAIRS-1:0] lvl;
  } cdr_lines_t;

  // card side held low after reset, host side released (high)
  localparam logic CDR_CARD_RST_LVL = 1'b0;
  localparam logic CDR_HOST_RST_LVL = 1'b1;
  localparam logic [1:0] CDR_PREV_RST = 2'h3;

endpackage : cdr_pkg

/* File: src/cdr_pair.sv */
// one repeater pair: direction follows first falling edge
module cdr_pair (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_en,
  input wire logic host_in,
  input wire logic card_in,
  output logic host_drive_low,
  output logic card_drive_low,
  output cdr_pkg::cdr_dir_t dir
);

  typedef struct packed {
    cdr_pkg::cdr_dir_t dir;
    logic [1:0] prev;  // {host, card} last levels
  } cdr_pair_st_t;

  cdr_pair_st_t st;
  cdr_pair_st_t next_st;
  logic host_fall;
  logic card_fall;
  logic host_rise;
  logic card_rise;

  // ---------------------------------------------------------------
  // edge detect and direction
  // ---------------------------------------------------------------
  assign host_fall = st.prev[1] & ~host_in;
  assign card_fall = st.prev[0] & ~card_in;
  assign host_rise = ~st.prev[1] & host_in;
  assign card_rise = ~st.prev[0] & card_in;

  // host wins a tie; both falling at once is a bus conflict anyway
  always_comb begin
    next_st = st;
    next_st.prev = {host_in, card_in};
    if (!rx_en) begin
      next_st.dir = cdr_pkg::CDR_NEUTRAL;
    end else begin
      case (st.dir)
        cdr_pkg::CDR_NEUTRAL: begin
          if (host_fall) begin
            next_st.dir = cdr_pkg::CDR_HOST_IN;
          end else if (card_fall) begin
            next_st.dir = cdr_pkg::CDR_CARD_IN;
          end
        end
        cdr_pkg::CDR_HOST_IN: begin
          if (host_rise) begin
            next_st.dir = cdr_pkg::CDR_NEUTRAL;
          end
        end
        cdr_pkg::CDR_CARD_IN: begin
          if (card_rise) begin
            next_st.dir = cdr_pkg::CDR_NEUTRAL;
          end
        end
        default: next_st.dir = cdr_pkg::CDR_NEUTRAL;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.dir <= cdr_pkg::CDR_NEUTRAL;
      st.prev <= cdr_pkg::CDR_PREV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // output follows input
  assign host_drive_low = (st.dir == cdr_pkg::CDR_CARD_IN) & ~card_in;
  assign card_drive_low = (st.dir == cdr_pkg::CDR_HOST_IN) & ~host_in;
  assign dir = st.dir;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_fall_selects;
    @(posedge clk) disable iff (rst)
      (rx_en && st.dir == cdr_pkg::CDR_NEUTRAL && host_fall) |=> (st.dir == cdr_pkg::CDR_HOST_IN);
  endproperty
  a_fall_selects: assert property (p_fall_selects) else $error("host fall not selected");

  property p_card_fall;
    @(posedge clk) disable iff (rst)
      (rx_en && st.dir == cdr_pkg::CDR_NEUTRAL && !host_fall && card_fall)
        |=> (st.dir == cdr_pkg::CDR_CARD_IN);
  endproperty
  a_card_fall: assert property (p_card_fall) else $error("card fall not selected");

  property p_rise_release;
    @(posedge clk) disable iff (rst)
      (st.dir == cdr_pkg::CDR_HOST_IN && host_rise) |=> (st.dir == cdr_pkg::CDR_NEUTRAL);
  endproperty
  a_rise_release: assert property (p_rise_release) else $error("rise did not release");

  property p_card_release;
    @(posedge clk) disable iff (rst)
      (st.dir == cdr_pkg::CDR_CARD_IN && card_rise) |=> (st.dir == cdr_pkg::CDR_NEUTRAL);
  endproperty
  a_card_release: assert property (p_card_release) else $error("card rise did not release");

  property p_neutral_quiet;
    @(posedge clk) disable iff (rst)
      (st.dir == cdr_pkg::CDR_NEUTRAL) |-> (!host_drive_low && !card_drive_low);
  endproperty
  a_neutral_quiet: assert property (p_neutral_quiet) else $error("neutral drives low");

  property p_follow;
    @(posedge clk) disable iff (rst)
      (st.dir == cdr_pkg::CDR_HOST_IN) |-> (card_drive_low == !host_in);
  endproperty
  a_follow: assert property (p_follow) else $error("card side not following");

endmodule : cdr_pair

/* File: verification/cdr_far_model.sv */
// ---------------------------------------------------------------
// far side: pulled-up open-drain lines on host and card
// ---------------------------------------------------------------
module cdr_far_model (
  // pull requests from the bench, high pulls the line low
  input wire logic [2:0] host_pull_in,
  input wire logic [2:0] card_pull_in,
  // design drivers
  input wire cdr_pkg::cdr_lines_t host_drv_in,
  input wire cdr_pkg::cdr_lines_t host_oe_in,
  input wire cdr_pkg::cdr_lines_t card_drv_in,
  input wire cdr_pkg::cdr_lines_t card_oe_in,
  // resolved wire levels
  output cdr_pkg::cdr_lines_t host_lvl_out,
  output cdr_pkg::cdr_lines_t card_lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired-and: pull-up wins only when nobody sinks the line
  assign host_lvl_out.lvl = ~(host_pull_in | (host_oe_in.lvl & ~host_drv_in.lvl));
  assign card_lvl_out.lvl = ~(card_pull_in | (card_oe_in.lvl & ~card_drv_in.lvl));
endmodule // cdr_far_model

/* File: verification/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx = 1'b0;
  logic [2:0] hp = 3'h0;
  logic [2:0] cp = 3'h0;
  logic held;
  cdr_pkg::cdr_lines_t h_lvl, c_lvl, h_drv, h_oe, c_drv, c_oe;
  int n_mismatch = 0;
  int n_checks = 0;

  cdr_repeater u_cdr_repeater (.REF_CLK_IN(clk), .RST_IN(rst), .RX_ENABLE_IN(rx),
    .HOST_LINE_IN(h_lvl), .CARD_LINE_IN(c_lvl), .HOST_LINE_OUT(h_drv),
    .HOST_LINE_OE_OUT(h_oe), .CARD_LINE_OUT(c_drv), .CARD_LINE_OE_OUT(c_oe),
    .CARD_HELD_LOW_OUT(held));
  cdr_far_model u_cdr_far_model (.host_pull_in(hp), .card_pull_in(cp),
    .host_drv_in(h_drv), .host_oe_in(h_oe), .card_drv_in(c_drv), .card_oe_in(c_oe),
    .host_lvl_out(h_lvl), .card_lvl_out(c_lvl));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // expectations and compares
  // ---------------------------------------------------------------
  // host wins a same-cycle tie, so card pull only counts alone
  function automatic logic [2:0] exp_card_oe(logic r, logic [2:0] h);
    return r ? h : 3'h7;
  endfunction
  function automatic logic [2:0] exp_host_oe(logic r, logic [2:0] h, logic [2:0] c);
    return r ? (c & ~h) : 3'h0;
  endfunction
  task automatic chk_lines(string what, logic [2:0] exp, logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  // two edges: the fall is sampled and the direction registered on the first, the second is margin
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
    chk_lines("card oe", exp_card_oe(rx, hp), c_oe.lvl);
    chk_lines("host oe", exp_host_oe(rx, hp, cp), h_oe.lvl);
    chk_lines("host drive", 3'h0, h_drv.lvl);
    chk_lines("card drive", 3'h0, c_drv.lvl);
  endtask
  task automatic drive(logic [2:0] h, logic [2:0] c);
    @(posedge clk);
    hp <= h;
    cp <= c;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [2:0] m;
    void'($urandom(32'h0000_0b48));
    repeat (3) @(posedge clk);
    #1;
    chk_lines("card oe in reset", 3'h7, c_oe.lvl);
    chk_lines("host oe in reset", 3'h0, h_oe.lvl);
    @(posedge clk);
    rst <= 1'b0;
    settle();
    chk_bit("held low", 1'b1, held);
    @(posedge clk);
    rx <= 1'b1;
    settle();
    chk_bit("held low", 1'b0, held);
    // corners: each pair from host, from card, and a tie; then random masks
    for (int k = 0; k < 29; k++) begin
      m = 3'h1 << (k / 3);
      if (k < 9) begin
        drive((k % 3 != 1) ? m : 3'h0, (k % 3 != 0) ? m : 3'h0);
      end else begin
        drive(3'($urandom), 3'($urandom));
      end
      settle();
      drive(3'h0, 3'h0);
      settle();
    end
    // mid-run reset with host aux one held low across it: the fall against
    // the reset prev is seen while rx_on is still low, so no direction comes back
    drive(3'h2, 3'h0);
    settle();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_lines("card oe in reset", 3'h7, c_oe.lvl);
    chk_lines("host oe in reset", 3'h0, h_oe.lvl);
    chk_bit("held low", 1'b1, held);
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_lines("card oe after reset", 3'h0, c_oe.lvl);
    chk_bit("held low", 1'b0, held);
    drive(3'h0, 3'h0);
    settle();
    // drop reception in mid-transfer
    drive(3'h1, 3'h0);
    settle();
    @(posedge clk);
    rx <= 1'b0;
    settle();
    chk_bit("held low", 1'b1, held);
    give_verdict();
  end

  // watchdog well past the expected few hundred cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_top
